// ==== dpmc_consts.svh ====
`ifndef DPMC_CONSTS_SVH
`define DPMC_CONSTS_SVH

// Address layout of the memory address register.
`define MAR_W           15
`define MAR_MOD_HI      14
`define MAR_MOD_LO      13
`define MAR_GRP_HI      2
`define MAR_GRP_LO      1
`define MAR_SMOD_HI     14
`define MAR_SMOD_LO     11
`define MAR_ILV_BIT     0
// Stored word layout.
`define WORD_W          18
`define DATA_W          16
`define PAR_LO_BIT      16
`define PAR_HI_BIT      17
// Matrix sizes in words.
`define STATIC_WORDS    1024
`define DYNAMIC_WORDS   4096
// Timing at the 100 ns reference clock.
`define CLK_PERIOD_NS   100
`define STATIC_CYC_NS   300
`define DYNAMIC_CYC_NS  450
`define STATIC_CYC_CLKS  (`STATIC_CYC_NS / `CLK_PERIOD_NS)
`define DYNAMIC_CYC_CLKS (`DYNAMIC_CYC_NS / `CLK_PERIOD_NS)
`define REFRESH_PERIOD_NS 1000000
`define REFRESH_ROWS    32
`define REFRESH_GAP_CLKS ((`REFRESH_PERIOD_NS / `CLK_PERIOD_NS) / `REFRESH_ROWS)
`define ROW_W           5

`endif

// ==== dpmc_pkg.sv ====
package dpmc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_LOAD   = 3'b001,
        ST_PRECHG = 3'b010,
        ST_ACCESS = 3'b011,
        ST_DONE   = 3'b100
    } cyc_state_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_FAST = 2'b01,
        SRC_PERI = 2'b10,
        SRC_REFR = 2'b11
    } source_t;
endpackage

// ==== parity_gen.sv ====
`timescale 1ns/1ns
`include "dpmc_consts.svh"

module parity_gen (
    input  wire logic [`DATA_W-1:0] data,
    output wire logic [`WORD_W-1:0] word
);
    // Even parity: the parity bit makes each byte plus its bit hold an even count of ones.
    assign word = {^data[15:8], ^data[7:0], data};
endmodule

// ==== refresh_gen.sv ====
`timescale 1ns/1ns
`include "dpmc_consts.svh"

module refresh_gen #(
    parameter int GAP_CLKS = `REFRESH_GAP_CLKS
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              enable,
    input  wire logic              served,
    output logic                   req_r,
    output logic [`ROW_W-1:0]      row_r
);
    logic [15:0]          cnt_r;
    logic [15:0]          cnt_nxt;
    logic                 req_nxt;
    logic [`ROW_W-1:0]    row_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        req_nxt = req_r;
        row_nxt = row_r;
        if (!enable) begin
            cnt_nxt = 16'h0000;
            req_nxt = 1'b0;
        end else begin
            if (cnt_r == 16'(GAP_CLKS - 1)) begin
                cnt_nxt = 16'h0000;
                req_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
            // A tick that lands on the serving cycle keeps the request pending.
            if (served && !(cnt_r == 16'(GAP_CLKS - 1))) begin
                req_nxt = 1'b0;
            end
            if (served) begin
                row_nxt = row_r + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_r <= 16'h0000;
            req_r <= 1'b0;
            row_r <= 5'h00;
        end else begin
            cnt_r <= cnt_nxt;
            req_r <= req_nxt;
            row_r <= row_nxt;
        end
    end
endmodule

// ==== dual_port_memory_controller.sv ====
// Functional notes
// - Drives four static or four dynamic modules.
// - Memory is always a slave.
// - Cycle at most 300 or 450 ns.
// - Word is 18 bits with byte parity.
// - Static modules select on bits 14:11.
// - Dynamic modules select 14:13, group 02:01.
// - Dynamic accesses include a precharge interval.
// - Dynamic memory refreshed every 1 ms.
// - Priority arbitration, winner into address register.
// - Addresses mapped bit for bit, then strobed.
// - Write register holds word until strobed.
// - Parity generated into two top stages.
// - Peripheral data via interface, fast direct.
// - Read register captures word on reads.
// - Read data to both buses together.
// - Fast bus unidirectional, peripheral bidirectional.
// - Control signals decode read or write.
// - Decode module, section, byte mode, interleave.
// - Write strobes address, data, then enable.
// - No write-back after a read.
// - Low parity bit 16, high bit 17.
// - Byte write touches only its byte.
// - Refresh steps 32 rows per 1 ms.
// - Static modules: no refresh, no precharge.
`timescale 1ns/1ns
`include "dpmc_consts.svh"

module dual_port_memory_controller #(
    parameter int                  REFRESH_GAP = `REFRESH_GAP_CLKS,
    parameter logic [3:0]          STATIC_JUMPER0 = 4'h0,
    parameter logic [1:0]          DYNAMIC_JUMPER0 = 2'h0
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              dynamic_fitted,
    input  wire logic              parity_fitted,
    input  wire logic              fast_req,
    input  wire logic              fast_write,
    input  wire logic              fast_byte,
    input  wire logic [`MAR_W-1:0] fast_addr,
    input  wire logic [`DATA_W-1:0] fast_wdata,
    output logic                   fast_ack_r,
    output logic [`DATA_W-1:0]     fast_rdata_r,
    input  wire logic              peri_req,
    input  wire logic              peri_write,
    input  wire logic              peri_byte,
    input  wire logic [`MAR_W-1:0] peri_addr,
    input  wire logic [`DATA_W-1:0] peri_data_in,
    output logic [`DATA_W-1:0]     peri_data_out_r,
    output logic                   peri_data_oe_r,
    output logic                   peri_ack_r
);
    localparam int DEPTH = 4 * `DYNAMIC_WORDS;

    // Peripheral bus signals come from another clock domain. The master holds them
    // stable from before its request until the acknowledge, so the bundle settles together.
    logic [1:0]               peri_req_s;
    logic                     peri_write_s1, peri_write_s2, peri_byte_s1, peri_byte_s2;
    logic [`MAR_W-1:0]        peri_addr_s1, peri_addr_s2;
    logic [`DATA_W-1:0]       peri_din_s1, peri_din_s2;

    dpmc_pkg::cyc_state_t     state_r, state_nxt;
    dpmc_pkg::source_t        src_r, src_nxt;
    logic [`MAR_W-1:0]        mar_r, mar_nxt;
    logic [`WORD_W-1:0]       wreg_r, wreg_nxt;
    logic [`WORD_W-1:0]       rreg_r, rreg_nxt;
    logic                     wr_r, wr_nxt, byte_r, byte_nxt;
    logic                     fast_ack_nxt, peri_ack_nxt, peri_oe_nxt, refr_served;
    logic [`DATA_W-1:0]       fast_rd_nxt, peri_do_nxt;
    logic                     peri_busy_r, peri_busy_nxt;
    logic [`WORD_W-1:0]       gen_word, cell_word;
    logic [`DATA_W-1:0]       wsrc_data;
    logic                     refr_req;
    logic [`ROW_W-1:0]        refr_row;
    logic                     mod_hit;
    logic [1:0]               mod_idx;
    logic [13:0]              cell_idx;
    logic                     lane_lo, lane_hi;
    logic                     mem_we;

    logic [`WORD_W-1:0]       mem [0:DEPTH-1];

    // Module select per technology: static by 14:11, dynamic by 14:13.
    function automatic logic [2:0] module_sel(input logic [`MAR_W-1:0] a, input logic dyn);
        logic [3:0] rel;
        rel = a[`MAR_SMOD_HI:`MAR_SMOD_LO] - STATIC_JUMPER0;
        if (dyn) begin
            module_sel = {1'b1, a[`MAR_MOD_HI:`MAR_MOD_LO] - DYNAMIC_JUMPER0};
        end else begin
            module_sel = {(rel < 4'h4), rel[1:0]};
        end
    endfunction

    // Word index inside the array; bit 0 only picks the byte lane.
    function automatic logic [13:0] cell_index(input logic [1:0] idx, input logic [`MAR_W-1:0] a);
        cell_index = {idx, a[12:1]};
    endfunction

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            peri_req_s    <= 2'b00;
            peri_write_s1 <= 1'b0;
            peri_write_s2 <= 1'b0;
            peri_byte_s1  <= 1'b0;
            peri_byte_s2  <= 1'b0;
            peri_addr_s1  <= 15'h0000;
            peri_addr_s2  <= 15'h0000;
            peri_din_s1   <= 16'h0000;
            peri_din_s2   <= 16'h0000;
        end else begin
            peri_req_s    <= {peri_req_s[0], peri_req};
            peri_write_s1 <= peri_write;
            peri_write_s2 <= peri_write_s1;
            peri_byte_s1  <= peri_byte;
            peri_byte_s2  <= peri_byte_s1;
            peri_addr_s1  <= peri_addr;
            peri_addr_s2  <= peri_addr_s1;
            peri_din_s1   <= peri_data_in;
            peri_din_s2   <= peri_din_s1;
        end
    end

    // A refresh never waits behind the buses, only behind the cycle in flight.
    // refresh timer
    refresh_gen #(
        .GAP_CLKS (REFRESH_GAP)
    ) u_refresh (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .enable  (dynamic_fitted),
        .served  (refr_served),
        .req_r   (refr_req),
        .row_r   (refr_row)
    );

    // peripheral data through synchroniser, fast data direct
    assign wsrc_data = (src_nxt == dpmc_pkg::SRC_PERI) ? peri_din_s2 : fast_wdata;

    parity_gen u_parity (
        .data (wsrc_data),
        .word (gen_word)
    );

    assign {mod_hit, mod_idx} = module_sel(mar_r, dynamic_fitted);
    assign cell_idx = cell_index(mod_idx, mar_r);
    assign cell_word = mem[cell_idx];
    // The refresh timer clears its request on the grant edge itself.
    assign refr_served = (state_r == dpmc_pkg::ST_IDLE) && (src_nxt == dpmc_pkg::SRC_REFR);
    // Byte lanes written: both for a word, the one picked by bit 0 for a byte.
    assign lane_lo = !byte_r || !mar_r[`MAR_ILV_BIT];
    assign lane_hi = !byte_r || mar_r[`MAR_ILV_BIT];
    // Addresses outside the fitted modules complete but write nothing; their
    // read word is whatever the decoded cell holds, as this bus has no error path.
    // no write-back
    assign mem_we = (state_r == dpmc_pkg::ST_ACCESS) && wr_r && mod_hit
                    && (src_r != dpmc_pkg::SRC_REFR);

    always_comb begin
        state_nxt     = state_r;
        src_nxt       = src_r;
        mar_nxt       = mar_r;
        wreg_nxt      = wreg_r;
        rreg_nxt      = rreg_r;
        wr_nxt        = wr_r;
        byte_nxt      = byte_r;
        fast_ack_nxt  = 1'b0;
        peri_ack_nxt  = peri_ack_r;
        peri_oe_nxt   = peri_data_oe_r;
        fast_rd_nxt   = fast_rdata_r;
        peri_do_nxt   = peri_data_out_r;
        peri_busy_nxt = peri_busy_r;
        // Peripheral handshake ends when the master drops its request.
        if (!peri_req_s[1]) begin
            peri_ack_nxt  = 1'b0;
            peri_oe_nxt   = 1'b0;
            peri_busy_nxt = 1'b0;
        end
        case (state_r)
            dpmc_pkg::ST_IDLE: begin
                // only answers requests
                // A fast request still high in the cycle after its acknowledge is the one
                // just served; its master lowers it at that edge, so it is not taken again.
                // A served peripheral request must fall before another is taken.
                if (refr_req && dynamic_fitted) begin
                    src_nxt = dpmc_pkg::SRC_REFR;
                    mar_nxt = {10'h000, refr_row};
                    wr_nxt  = 1'b0;
                end else if (fast_req && !fast_ack_r) begin
                    src_nxt  = dpmc_pkg::SRC_FAST;
                    mar_nxt  = fast_addr;
                    wr_nxt   = fast_write;
                    byte_nxt = fast_byte;
                end else if (peri_req_s[1] && !peri_busy_r) begin
                    src_nxt  = dpmc_pkg::SRC_PERI;
                    mar_nxt  = peri_addr_s2;
                    wr_nxt   = peri_write_s2;
                    byte_nxt = peri_byte_s2;
                end else begin
                    src_nxt = dpmc_pkg::SRC_NONE;
                end
                if (src_nxt != dpmc_pkg::SRC_NONE) begin
                    wreg_nxt  = gen_word;
                    state_nxt = dpmc_pkg::ST_LOAD;
                end
            end
            dpmc_pkg::ST_LOAD: begin
                state_nxt = dynamic_fitted ? dpmc_pkg::ST_PRECHG : dpmc_pkg::ST_ACCESS;
            end
            dpmc_pkg::ST_PRECHG: begin
                state_nxt = dpmc_pkg::ST_ACCESS;
            end
            dpmc_pkg::ST_ACCESS: begin
                // capture read word; reads never write back
                // Refresh cycles read the array but leave the read register alone,
                // so neither bus ever sees a refresh word.
                if (!wr_r && src_r != dpmc_pkg::SRC_REFR) begin
                    rreg_nxt = parity_fitted ? cell_word : {2'b00, cell_word[15:0]};
                end
                state_nxt = dpmc_pkg::ST_DONE;
            end
            dpmc_pkg::ST_DONE: begin
                // cycle closes within 300 or 450 ns
                state_nxt = dpmc_pkg::ST_IDLE;
                // The fast acknowledge is one pulse, the peripheral one holds until its request falls; read data stands until the next read.
                // data to both buses at once
                fast_rd_nxt = rreg_r[15:0];
                peri_do_nxt = rreg_r[15:0];
                if (src_r == dpmc_pkg::SRC_FAST) begin
                    fast_ack_nxt = 1'b1;
                end else if (src_r == dpmc_pkg::SRC_PERI) begin
                    peri_ack_nxt  = 1'b1;
                    peri_busy_nxt = 1'b1;
                    peri_oe_nxt   = !wr_r;
                end
                src_nxt = dpmc_pkg::SRC_NONE;
            end
            default: begin
                state_nxt = dpmc_pkg::ST_IDLE;
            end
        endcase
    end

    // byte writes keep the other byte and its parity
    // The array has no reset, as matrix cells power up unknown.
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            if (lane_lo) begin
                mem[cell_idx][7:0]         <= wreg_r[7:0];
                mem[cell_idx][`PAR_LO_BIT] <= wreg_r[`PAR_LO_BIT] & parity_fitted;
            end
            if (lane_hi) begin
                mem[cell_idx][15:8]        <= byte_r ? wreg_r[7:0] : wreg_r[15:8];
                mem[cell_idx][`PAR_HI_BIT] <=
                    (byte_r ? wreg_r[`PAR_LO_BIT] : wreg_r[`PAR_HI_BIT]) & parity_fitted;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r         <= dpmc_pkg::ST_IDLE;
            src_r           <= dpmc_pkg::SRC_NONE;
            mar_r           <= 15'h0000;
            wreg_r          <= 18'h00000;
            rreg_r          <= 18'h00000;
            wr_r            <= 1'b0;
            byte_r          <= 1'b0;
            fast_ack_r      <= 1'b0;
            peri_ack_r      <= 1'b0;
            peri_data_oe_r  <= 1'b0;
            fast_rdata_r    <= 16'h0000;
            peri_data_out_r <= 16'h0000;
            peri_busy_r     <= 1'b0;
        end else begin
            state_r         <= state_nxt;
            src_r           <= src_nxt;
            mar_r           <= mar_nxt;
            wreg_r          <= wreg_nxt;
            rreg_r          <= rreg_nxt;
            wr_r            <= wr_nxt;
            byte_r          <= byte_nxt;
            fast_ack_r      <= fast_ack_nxt;
            peri_ack_r      <= peri_ack_nxt;
            peri_data_oe_r  <= peri_oe_nxt;
            fast_rdata_r    <= fast_rd_nxt;
            peri_data_out_r <= peri_do_nxt;
            peri_busy_r     <= peri_busy_nxt;
        end
    end
endmodule

// ==== dpmc_checker_assertions.sv ====
`timescale 1ns/1ns
module dpmc_checker (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        fast_req,
    input wire logic        fast_ack_r,
    input wire logic [15:0] fast_rdata_r,
    input wire logic        peri_req,
    input wire logic        peri_write,
    input wire logic        peri_ack_r,
    input wire logic        peri_data_oe_r,
    input wire logic [15:0] peri_data_out_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_fast_start; $rose(fast_req); endsequence
    sequence s_fast_done; ##[1:40] fast_ack_r; endsequence
    property p_fast_bounded; s_fast_start |-> s_fast_done; endproperty
    a_fast_bounded: assert property (p_fast_bounded) else $error("fast cycle late");
    property p_ack_pulse; fast_ack_r |=> !fast_ack_r; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("fast ack too wide");
    property p_ack_cause; fast_ack_r |-> $past(fast_req, 4); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("fast ack unasked");
    property p_peri_hold; peri_ack_r && peri_req && $past(peri_req) |=> peri_ack_r; endproperty
    a_peri_hold: assert property (p_peri_hold) else $error("peri ack dropped");
    property p_peri_release; $fell(peri_req) |-> ##[1:4] !peri_ack_r; endproperty
    a_peri_release: assert property (p_peri_release) else $error("peri ack stuck");
    property p_oe_read; $rose(peri_data_oe_r) |-> peri_ack_r && !peri_write; endproperty
    a_oe_read: assert property (p_oe_read) else $error("peri drive wrong");
    property p_same_data; $rose(peri_data_oe_r) |-> peri_data_out_r == fast_rdata_r; endproperty
    a_same_data: assert property (p_same_data) else $error("read data differs");
    property p_rdata_hold; $changed(fast_rdata_r) |-> fast_ack_r || $rose(peri_ack_r); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind dual_port_memory_controller dpmc_checker i_chk (.*);

// ==== peri_bus_master.sv ====
`timescale 1ns/1ns
module peri_bus_master (
    input  wire logic        ref_clk,
    input  wire logic        peri_ack_r,
    input  wire logic        peri_data_oe_r,
    input  wire logic [15:0] peri_data_out_r,
    output logic             peri_req,
    output logic             peri_write,
    output logic             peri_byte,
    output logic [14:0]      peri_addr,
    output logic [15:0]      peri_data_in
);
    logic        drive = 1'b0;
    logic [15:0] wd = 16'h0;
    logic [15:0] last = 16'h0;
    initial {peri_req, peri_write, peri_byte, peri_addr} = 18'h0;
    // Shared wire level.
    // Undriven, the line toggles so a stale word is never mistaken for data.
    always @* begin
        if (peri_data_oe_r) peri_data_in = peri_data_out_r;
        else if (drive) peri_data_in = wd;
        else peri_data_in = ~last;
    end
    always @(posedge ref_clk) last <= peri_data_in;
    task automatic xfer(input logic w, input logic b, input logic [14:0] a,
                        input logic [15:0] d, input int hold, output logic [15:0] q);
        int k;
        k = 0;
        @(posedge ref_clk);
        peri_write <= w;
        peri_byte <= b;
        peri_addr <= a;
        wd <= d;
        drive <= w;
        @(posedge ref_clk);
        peri_req <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (peri_ack_r !== 1'b1 && k < 80);
        q = peri_data_out_r;
        repeat (hold) @(posedge ref_clk);
        peri_req <= 1'b0;
        drive <= 1'b0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (peri_ack_r !== 1'b0 && k < 90);
    endtask
endmodule

// ==== test_dual_port_memory_controller.sv ====
`timescale 1ns/1ns
module test_dual_port_memory_controller;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        dynamic_fitted = 1'b0;
    logic        parity_fitted = 1'b1;
    logic        fast_req = 1'b0;
    logic        fast_write = 1'b0;
    logic        fast_byte = 1'b0;
    logic [14:0] fast_addr = 15'h0;
    logic [15:0] fast_wdata = 16'h0;
    logic        fast_ack_r, peri_req, peri_write, peri_byte, peri_ack_r, peri_data_oe_r;
    logic [14:0] peri_addr;
    logic [15:0] fast_rdata_r, peri_data_in, peri_data_out_r, q;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cycles = 0;
    int          n = 0;
    always #50 ref_clk = ~ref_clk;
    dual_port_memory_controller #(.REFRESH_GAP(8)) i_dut (.*);
    peri_bus_master i_peri (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic fast_op(input logic w, input logic b, input logic [14:0] a,
                           input logic [15:0] d);
        n = 0;
        @(posedge ref_clk);
        fast_req <= 1'b1;
        fast_write <= w;
        fast_byte <= b;
        fast_addr <= a;
        fast_wdata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (fast_ack_r !== 1'b1 && n < 60);
        // Released at the edge that samples the acknowledge.
        fast_req <= 1'b0;
    endtask
    task automatic t_fast_rw();
        fast_op(1'b1, 1'b0, 15'h0010, 16'h1234);
        chk(16'(n), 16'h5);
        fast_op(1'b0, 1'b0, 15'h0010, 16'h0);
        chk(16'(n), 16'h5);
        chk(fast_rdata_r, 16'h1234);
    endtask
    task automatic t_byte();
        fast_op(1'b1, 1'b1, 15'h0011, 16'h00ab);
        fast_op(1'b0, 1'b0, 15'h0010, 16'h0);
        chk(fast_rdata_r, 16'hab34);
        fast_op(1'b1, 1'b1, 15'h0010, 16'hffcd);
        fast_op(1'b0, 1'b0, 15'h0010, 16'h0);
        chk(fast_rdata_r, 16'habcd);
    endtask
    task automatic t_peri();
        i_peri.xfer(1'b1, 1'b0, 15'h0020, 16'h5a5a, 0, q);
        i_peri.xfer(1'b0, 1'b0, 15'h0020, 16'h0, 4, q);
        chk(q, 16'h5a5a);
        chk(fast_rdata_r, 16'h5a5a);
        i_peri.xfer(1'b0, 1'b0, 15'h0010, 16'h0, 0, q);
        chk(q, 16'habcd);
    endtask
    task automatic t_race();
        fork
            i_peri.xfer(1'b1, 1'b0, 15'h0032, 16'h3c3c, 0, q);
            begin
                repeat (4) @(posedge ref_clk);
                fast_op(1'b1, 1'b0, 15'h0030, 16'hc3c3);
            end
        join
        chk({15'h0, n > 5}, 16'h1);
        fast_op(1'b0, 1'b0, 15'h0032, 16'h0);
        chk(fast_rdata_r, 16'h3c3c);
        fast_op(1'b0, 1'b0, 15'h0030, 16'h0);
        chk(fast_rdata_r, 16'hc3c3);
    endtask
    task automatic t_dynamic();
        @(posedge ref_clk);
        rstn <= 1'b0;
        dynamic_fitted <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        fast_op(1'b1, 1'b0, 15'h0ffe, 16'h9876);
        chk({15'h0, n >= 6 && n <= 12}, 16'h1);
        repeat (60) @(posedge ref_clk);
        fast_op(1'b0, 1'b0, 15'h0ffe, 16'h0);
        chk(fast_rdata_r, 16'h9876);
        i_peri.xfer(1'b0, 1'b0, 15'h0ffe, 16'h0, 0, q);
        chk(q, 16'h9876);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        chk(fast_rdata_r, 16'h0);
        t_fast_rw();
        t_byte();
        t_peri();
        t_race();
        t_dynamic();
        report_and_stop();
    end
endmodule
